// file: logic/prio_apb_port.sv
/*
  APB slave handshake for the priority bank: one wait state, registered
  answer, error on unmapped addresses.
  Assumes the master holds its request until pready is sampled high.
*/
`timescale 1ns/1ps
module prio_apb_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic mapped,
  input wire logic [prio_bank_pkg::DATA_W-1:0] rd_word,
  output logic [prio_bank_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wr_commit
);
  import prio_bank_pkg::*;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_ANSWER = 2'b10
  } port_state_e;

  port_state_e state;
  port_state_e next_state;
  logic [DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic access_start;

  // ---------------------------------------------------------------
  // handshake
  // ---------------------------------------------------------------
  assign access_start = psel && penable && !pready;
  assign pready = state[1];
  assign wr_commit = psel && penable && pready && pwrite && mapped;

  always_comb begin
    next_state = state;
    next_prdata = '0;
    next_pslverr = 1'b0;
    unique case (state)
      ST_WAIT: begin
        if (access_start) begin
          next_state = ST_ANSWER;
          next_pslverr = !mapped;
          next_prdata = (!pwrite && mapped) ? rd_word : '0;
        end
      end
      ST_ANSWER: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_WAIT;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  answer_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("answer not given after one wait state");

  unmapped_error_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    access_start && !mapped |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

endmodule // prio_apb_port

// file: logic/prio_bank.sv
/*
  Interrupt priority bank: five 16-bit registers of 3-bit priority
  fields behind an APB slave, with each level and its disable flag
  driven out to the arbitration logic.
  Assumes pclk at 50 MHz and an APB master that holds each request.

*/
`timescale 1ns/1ps
module prio_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [prio_bank_pkg::ADDR_W-1:0] paddr,
  input wire logic [prio_bank_pkg::DATA_W-1:0] pwdata,
  input wire logic [prio_bank_pkg::STRB_W-1:0] pstrb,
  output logic [prio_bank_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output prio_bank_pkg::levels_s levels,
  output logic [prio_bank_pkg::FIELD_COUNT-1:0] source_enabled
);
  import prio_bank_pkg::*;

  logic [2:0] sel_idx;
  logic mapped;
  logic wr_commit;
  logic [DATA_W-1:0] rd_word;
  logic [FIELD_COUNT-1:0][LEVEL_W-1:0] field_level;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    case (paddr)
      REG_ONE_OFFSET: sel_idx = 3'h0;
      REG_TWO_OFFSET: sel_idx = 3'h1;
      REG_THREE_OFFSET: sel_idx = 3'h2;
      REG_FOUR_OFFSET: sel_idx = 3'h3;
      REG_FIVE_OFFSET: sel_idx = 3'h4;
      default: sel_idx = REG_NONE;
    endcase
  end

  assign mapped = (sel_idx != REG_NONE);

  // ---------------------------------------------------------------
  // bus port
  // ---------------------------------------------------------------
  prio_apb_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .mapped(mapped),
    .rd_word(rd_word),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_commit(wr_commit)
  );

  // ---------------------------------------------------------------
  // priority fields
  // ---------------------------------------------------------------
  for (genvar i = 0; i < FIELD_COUNT; i++) begin : g_field
    field_wr_s wr;

    always_comb begin
      wr.idx = FIELD_REG[i];
      wr.data = pwdata[FIELD_LSB[i] +: LEVEL_W];
      wr.en = wr_commit && (sel_idx == FIELD_REG[i])
        && pstrb[FIELD_LSB[i][3]];
    end

    prio_field u_field (
      .pclk(pclk),
      .presetn(presetn),
      .wr(wr),
      .level(field_level[i]),
      .enabled(source_enabled[i])
    );
  end

  // field placement via the struct order
  assign levels = levels_s'(field_level);

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  // bits outside fields stay zero
  always_comb begin
    rd_word = '0;
    for (int f = 0; f < FIELD_COUNT; f++) begin
      if (FIELD_REG[f] == sel_idx) begin
        rd_word[FIELD_LSB[f] +: LEVEL_W] = field_level[f];
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic wr_hi;
  logic wr_lo;
  assign wr_hi = wr_commit && pstrb[1];
  assign wr_lo = wr_commit && pstrb[0];

  gaps_read_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:16] == 16'h0000 && !prdata[15]
      && !prdata[11] && !prdata[7] && !prdata[3])
    else $error("separator or upper bit read as one");

  reg_one_hi_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && sel_idx == 3'h0 |=>
      levels.timer_two_level == $past(pwdata[14:12])
      && levels.out_compare_two_level == $past(pwdata[10:8]))
    else $error("first register high fields misplaced");

  reg_one_lo_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lo && sel_idx == 3'h0 |=>
      levels.in_capture_two_level == $past(pwdata[6:4])
      && levels.dma_chan_zero_level == $past(pwdata[2:0]))
    else $error("first register low fields misplaced");

  reg_two_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && wr_lo && sel_idx == 3'h1 |=>
      levels.uart_one_receive_level == $past(pwdata[14:12])
      && levels.spi_one_event_level == $past(pwdata[10:8])
      && levels.spi_one_error_level == $past(pwdata[6:4])
      && levels.timer_three_level == $past(pwdata[2:0]))
    else $error("second register fields misplaced");

  reg_three_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && wr_lo && sel_idx == 3'h2 |=>
      levels.dma_chan_one_level == $past(pwdata[10:8])
      && levels.adc_one_done_level == $past(pwdata[6:4])
      && levels.uart_one_transmit_level == $past(pwdata[2:0]))
    else $error("third register fields misplaced");

  reg_three_gap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_idx == 3'h2 |-> prdata[15:11] == 5'h00)
    else $error("third register upper bits not zero");

  reg_four_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && wr_lo && sel_idx == 3'h3 |=>
      levels.pin_change_level == $past(pwdata[14:12])
      && levels.i2c_one_master_level == $past(pwdata[6:4])
      && levels.i2c_one_slave_level == $past(pwdata[2:0]))
    else $error("fourth register fields misplaced");

  reg_four_gap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_idx == 3'h3 |-> prdata[11:7] == 5'h00)
    else $error("fourth register middle bits not zero");

  reg_five_map_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && wr_lo && sel_idx == 3'h4 |=>
      levels.in_capture_eight_level == $past(pwdata[14:12])
      && levels.in_capture_seven_level == $past(pwdata[10:8])
      && levels.adc_two_done_level == $past(pwdata[6:4])
      && levels.ext_irq_one_level == $past(pwdata[2:0]))
    else $error("fifth register fields misplaced");

  read_back_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && sel_idx == 3'h0 |=>
      prdata[15:0] == {1'b0, levels.timer_two_level,
        1'b0, levels.out_compare_two_level,
        1'b0, levels.in_capture_two_level,
        1'b0, levels.dma_chan_zero_level})
    else $error("read did not return stored fields");

  gap_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && sel_idx == 3'h3 && !pstrb[0] |=>
      $stable(levels.i2c_one_master_level)
      && $stable(levels.i2c_one_slave_level))
    else $error("write to empty bits changed a field");

  reset_enable_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> source_enabled == '1 && levels.pin_change_level == FIELD_RESET)
    else $error("sources not enabled at level four after reset");

  disabled_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lo && sel_idx == 3'h4 && pwdata[2:0] == LEVEL_OFF |=> !source_enabled[17])
    else $error("zero code left source enabled");

  // ---------------------------------------------------------------
  // checks: answers, lanes and read back
  // ---------------------------------------------------------------
  reset_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !pready && !pslverr && prdata == '0)
    else $error("bus answer not idle after reset");

  all_levels_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> levels == {FIELD_COUNT{FIELD_RESET}})
    else $error("a field did not reset to level four");

  idle_answer_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == '0 && !pslverr)
    else $error("read data or error shown outside an answer");

  quiet_bus_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_commit |=> $stable(levels))
    else $error("a field changed without a write");

  unmapped_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pwrite && !mapped |=> $stable(levels))
    else $error("write to an unmapped address changed a field");

  upper_lanes_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_commit && pstrb[1:0] == 2'b00 |=> $stable(levels))
    else $error("write on the upper lanes changed a field");

  reg_two_lanes_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && !wr_lo && sel_idx == 3'h1 |=>
      levels.uart_one_receive_level == $past(pwdata[14:12])
      && $stable(levels.spi_one_error_level)
      && $stable(levels.timer_three_level))
    else $error("high lane write on the second register touched low fields");

  reg_five_lanes_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lo && !wr_hi && sel_idx == 3'h4 |=>
      levels.adc_two_done_level == $past(pwdata[6:4])
      && $stable(levels.in_capture_eight_level)
      && $stable(levels.in_capture_seven_level))
    else $error("low lane write on the fifth register touched high fields");

  reg_one_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lo && sel_idx == 3'h0 && pwdata[2:0] == LEVEL_OFF |=> !source_enabled[3])
    else $error("zero code left the dma zero source enabled");

  pin_change_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_hi && sel_idx == 3'h3 && pwdata[14:12] == LEVEL_MAX |=>
      levels.pin_change_level == LEVEL_MAX && source_enabled[11])
    else $error("code seven did not give pin change level seven");

  adc_one_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_lo && sel_idx == 3'h2 && pwdata[6:4] == LEVEL_MIN |=>
      levels.adc_one_done_level == LEVEL_MIN && source_enabled[9])
    else $error("code one did not give adc one level one");

  read_back_two_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && sel_idx == 3'h1 |=>
      prdata[15:0] == {1'b0, levels.uart_one_receive_level,
        1'b0, levels.spi_one_event_level,
        1'b0, levels.spi_one_error_level,
        1'b0, levels.timer_three_level})
    else $error("second register read did not return stored fields");

  read_back_three_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && sel_idx == 3'h2 |=>
      prdata[15:0] == {5'h00, levels.dma_chan_one_level,
        1'b0, levels.adc_one_done_level,
        1'b0, levels.uart_one_transmit_level})
    else $error("third register read did not return stored fields");

  read_back_four_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && sel_idx == 3'h3 |=>
      prdata[15:0] == {1'b0, levels.pin_change_level, 5'h00,
        levels.i2c_one_master_level,
        1'b0, levels.i2c_one_slave_level})
    else $error("fourth register read did not return stored fields");

  read_back_five_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && !pwrite && sel_idx == 3'h4 |=>
      prdata[15:0] == {1'b0, levels.in_capture_eight_level,
        1'b0, levels.in_capture_seven_level,
        1'b0, levels.adc_two_done_level,
        1'b0, levels.ext_irq_one_level})
    else $error("fifth register read did not return stored fields");

endmodule // prio_bank

// file: logic/prio_bank_pkg.sv
/*
  Shared constants and types of the interrupt priority bank: register
  offsets, field placement, reset level and the carrier structs.
  Assumes a 32-bit APB with 12-bit byte addresses.
*/
package prio_bank_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W = 16;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_ONE_OFFSET = 12'h000;
  localparam logic [11:0] REG_TWO_OFFSET = 12'h004;
  localparam logic [11:0] REG_THREE_OFFSET = 12'h008;
  localparam logic [11:0] REG_FOUR_OFFSET = 12'h00C;
  localparam logic [11:0] REG_FIVE_OFFSET = 12'h010;
  localparam logic [2:0] REG_NONE = 3'h7;

  // ---------------------------------------------------------------
  // priority fields
  // ---------------------------------------------------------------
  localparam int LEVEL_W = 3;
  localparam int FIELD_COUNT = 18;
  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_MAX = 3'h7;
  // register index of each field, index 0 first
  localparam logic [2:0] FIELD_REG [FIELD_COUNT] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2,
    3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
  // lowest bit of each field within its register
  localparam logic [3:0] FIELD_LSB [FIELD_COUNT] = '{
    4'hC, 4'h8, 4'h4, 4'h0, 4'hC, 4'h8, 4'h4, 4'h0, 4'h8,
    4'h4, 4'h0, 4'hC, 4'h4, 4'h0, 4'hC, 4'h8, 4'h4, 4'h0};

  typedef logic [LEVEL_W-1:0] level_t;

  // member order follows field index 17 down to 0
  typedef struct packed {
    level_t ext_irq_one_level;
    level_t adc_two_done_level;
    level_t in_capture_seven_level;
    level_t in_capture_eight_level;
    level_t i2c_one_slave_level;
    level_t i2c_one_master_level;
    level_t pin_change_level;
    level_t uart_one_transmit_level;
    level_t adc_one_done_level;
    level_t dma_chan_one_level;
    level_t timer_three_level;
    level_t spi_one_error_level;
    level_t spi_one_event_level;
    level_t uart_one_receive_level;
    level_t dma_chan_zero_level;
    level_t in_capture_two_level;
    level_t out_compare_two_level;
    level_t timer_two_level;
  } levels_s;

  typedef struct packed {
    logic [2:0] idx;
    logic [LEVEL_W-1:0] data;
    logic en;
  } field_wr_s;

endpackage

// file: logic/prio_field.sv
/*
  One 3-bit priority field with its disable flag.
  Assumes the write strobe is a single-cycle pulse from the bus port.
*/
`timescale 1ns/1ps
module prio_field (
  input wire logic pclk,
  input wire logic presetn,
  input wire prio_bank_pkg::field_wr_s wr,
  output prio_bank_pkg::level_t level,
  output logic enabled
);
  import prio_bank_pkg::*;

  level_t next_level;
  logic next_enabled;

  // ---------------------------------------------------------------
  // field storage
  // ---------------------------------------------------------------
  // last written code
  // the level is the code itself
  always_comb begin
    next_level = level;
    if (wr.en) begin
      next_level = wr.data;
    end
    next_enabled = (next_level != LEVEL_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= FIELD_RESET;
      enabled <= 1'b1;
    end else begin
      level <= next_level;
      enabled <= next_enabled;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  reset_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> level == FIELD_RESET && enabled)
    else $error("field not at level four after reset");

  level_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr.en && wr.data == LEVEL_MAX |=> level == LEVEL_MAX && enabled)
    else $error("code seven did not give level seven");

  level_low_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr.en && wr.data == LEVEL_MIN |=> level == LEVEL_MIN && enabled)
    else $error("code one did not give level one");

  source_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    enabled == (level != LEVEL_OFF))
    else $error("disable flag disagrees with level");

  level_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr.en ##1 !wr.en |-> $stable(level))
    else $error("field changed without a write");

endmodule // prio_field

// file: testbench/prio_bank_tb.sv
/*
  Self-checking bench of the interrupt priority bank: an integer model of
  the eighteen priority fields is compared with every APB answer and with
  the level and enable outputs after each reset, each round of writes and each random access.
  Assumes the bank answers each APB access with one pready pulse.
*/
`timescale 1ns/1ps
module prio_bank_tb;
  import prio_bank_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [STRB_W-1:0] pstrb = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  levels_s levels;
  logic [FIELD_COUNT-1:0] source_enabled;
  int lvl [FIELD_COUNT];
  int miscompares = 0;
  int n_compared = 0;

  always #10 pclk = ~pclk;

  prio_bank i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .levels(levels),
    .source_enabled(source_enabled)
  );

  // ---------------------------------------------------------------
  // checking and model
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] model_word(input int r);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < FIELD_COUNT; i++) begin
      if (FIELD_REG[i] == r) w[FIELD_LSB[i] +: 3] = lvl[i][2:0];
    end
    return w;
  endfunction

  task automatic chk_outputs();
    logic [FIELD_COUNT*3-1:0] el;
    logic [FIELD_COUNT-1:0] ee;
    @(negedge pclk);
    for (int i = 0; i < FIELD_COUNT; i++) begin
      el[3*i +: 3] = lvl[i][2:0];
      ee[i] = (lvl[i] != 0);
    end
    chk_word(64'(levels), 64'(el), "levels");
    chk_word(64'(source_enabled), 64'(ee), "enables");
  endtask

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    logic [31:0] rd;
    logic err;
    logic mapped;
    int r;
    int n;
    mapped = (a[1:0] == 2'h0) && (a <= REG_FIVE_OFFSET);
    r = int'(a >> 2);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready and read data are taken at the rising edge, before its own updates land
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t no answer from the bank", $time);
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_word(64'(err), 64'(!mapped), "error flag");
    if (!wr) chk_word(64'(rd), mapped ? 64'(model_word(r)) : '0, "read data");
    if (wr && mapped) begin
      for (int i = 0; i < FIELD_COUNT; i++) begin
        if (FIELD_REG[i] == r && (FIELD_LSB[i] >= 8 ? s[1] : s[0]))
          lvl[i] = int'(d[FIELD_LSB[i] +: 3]);
      end
    end
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (lvl[i]) lvl[i] = 4;
  endtask

  task automatic read_all();
    for (int r = 0; r < 5; r++) apb(1'b0, 12'(4*r), '0, '0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [11:0] a;
    logic [2:0] c;
    void'($urandom(47));
    do_reset();
    chk_outputs();
    read_all();
    // every code, separator and upper bits written as ones
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      for (int r = 0; r < 5; r++)
        apb(1'b1, 12'(4*r), {16'hFFFF, 1'b1, c, 1'b1, c, 1'b1, c, 1'b1, c}, 4'hF);
      chk_outputs();
      read_all();
    end
    // unmapped and unaligned places leave every field alone
    apb(1'b1, 12'h014, 32'h00000000, 4'hF);
    apb(1'b1, 12'h006, 32'h00000000, 4'hF);
    apb(1'b0, 12'hFFC, '0, '0);
    chk_outputs();
    for (int k = 0; k < 80; k++) begin
      a = ($urandom % 4 == 0) ? 12'($urandom % 24) : 12'(4 * ($urandom % 5));
      apb(1'($urandom), a, $urandom, 4'($urandom));
      chk_outputs();
    end
    do_reset();
    chk_outputs();
    read_all();
    conclude();
  end
endmodule // prio_bank_tb
